// ===== hdl/rap_regs.svh
/*
 * Register offsets, field positions, reset values and protocol constants
 * of the register access packet server.
 * Assumes inclusion by bare name from the package and the testbench.
 */
`ifndef RAP_REGS_SVH
`define RAP_REGS_SVH

// Software register offsets on the local register port.
`define RAP_REG_CTRL 4'h0
`define RAP_REG_TIMEOUT 4'h4
`define RAP_REG_STATUS 4'h8
`define RAP_REG_LASTERR 4'hC

// Control register fields.
`define RAP_CTRL_VIA_SCB 0
`define RAP_CTRL_SEL_LSB 8
`define RAP_CTRL_SEL_MSB 10
`define RAP_CTRL_RST 32'h0000_0000
`define RAP_TIMEOUT_RST 32'h0000_FFFF

// Board select values.
`define RAP_BOARD_DIRECT 16'hFFFF
`define RAP_BOARD_MAX 16'h0004

// Operation codes.
`define RAP_OP_ENUM 4'h0
`define RAP_OP_WR_INC 4'h1
`define RAP_OP_WR_FIX 4'h2
`define RAP_OP_RDB_INC 4'h3
`define RAP_OP_RDB_FIX 4'h4
`define RAP_OP_RDN_INC 4'h5
`define RAP_OP_RDN_FIX 4'h6

// Completion codes.
`define RAP_ERR_NONE 32'hFFFF_FFFF
`define RAP_ERR_OP 32'h0000_0001
`define RAP_ERR_BOARD 32'h0000_0002
`define RAP_ERR_TIMEOUT 32'h0000_0003

// Server ports and streaming channels.
`define RAP_CMD_PORT 16'h22C3
`define RAP_STRM_PORT 16'h22C4
`define RAP_NCH 4
`define RAP_ROM_LEN 32'h0000_0006

`endif

// ===== hdl/rap_pkg.sv
/*
 * Types shared by the packet server and its stream slice.
 * Assumes rap_regs.svh is on the include path.
 */
package rap_pkg;
	`include "rap_regs.svh"

	// One 32-bit word with its valid qualifier.
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} rap_word_t;

	// Latched request header fields.
	typedef struct packed {
		logic [31:0] tag;
		logic [15:0] board;
		logic [3:0] op;
		logic [31:0] count;
		logic [31:0] addr;
	} rap_hdr_t;
endpackage

// ===== hdl/rap_stream_slice.sv
/*
 * Two-entry register slice that carries one streaming channel from the
 * logic that pushes words to the client socket, in one direction only.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module rap_stream_slice
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input rap_pkg::rap_word_t push_in,
	output logic push_ready_out,
	output rap_pkg::rap_word_t strm_out,
	input wire logic strm_ready_in
);
	import rap_pkg::*;

	rap_word_t out_r;
	logic [31:0] skid_r;
	logic skid_v_r;
	logic skid_v_nxt;
	logic rdy_r;
	logic take;
	logic drain;

	assign take = push_in.valid && rdy_r;
	assign drain = out_r.valid && strm_ready_in;
	assign push_ready_out = rdy_r;
	assign strm_out = out_r;

	always_comb
	begin
		skid_v_nxt = skid_v_r;
		if (drain)
			skid_v_nxt = 1'b0;
		else if (take && out_r.valid)
			skid_v_nxt = 1'b1;
	end

	// Words leave exactly as pushed; the skid keeps full rate. see RL16
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			out_r <= '0;
			skid_r <= 32'h0000_0000;
			skid_v_r <= 1'b0;
			rdy_r <= 1'b0;
		end
		else
		begin
			skid_v_r <= skid_v_nxt;
			rdy_r <= en_in && !skid_v_nxt; // see RL19
			if (drain)
			begin
				if (skid_v_r)
					out_r.data <= skid_r;
				else if (take)
					out_r.data <= push_in.data;
				out_r.valid <= skid_v_r || take;
			end
			else if (take)
			begin
				if (!out_r.valid)
				begin
					out_r.data <= push_in.data;
					out_r.valid <= 1'b1;
				end
				else
					skid_r <= push_in.data;
			end
		end
	end
endmodule // rap_stream_slice

// ===== hdl/rap_server.sv
/*
 * Binary request packet server: parses request words, performs register
 * or memory accesses on the target port, and builds reply words. Also
 * carries the raw streaming channels toward their client sockets.
 * Assumes a network stack that hands over request words in order and
 * takes reply words with valid/ready, and one clock with sync reset.
 */
// Implementation choices: the strobed register port and the address map.
// Functional notes
// RL1: Client increments packet tag every request.
// RL2: Reply carries the request's packet tag.
// RL3: Direct connection uses board select 0xFFFF.
// RL4: Via slow control: 0 itself, 1-4 sub-boards.
// RL5: Operation 0000 returns JSON board description.
// RL6: 0001 writes incrementing, 0010 writes fixed address.
// RL7: 0011/0100 blocking read, incrementing/fixed.
// RL8: 0101/0110 non-blocking read, incrementing/fixed.
// RL9: Word count counts 32-bit double words.
// RL10: Address field is access base address.
// RL11: Reply echoes operation, count, address unchanged.
// RL12: Reply reports words actually transferred.
// RL13: Completion code all ones on success.
// RL14: Request server listens on port 8899.
// RL15: Stream ports consecutive from 8900, one per FIFO.
// RL16: Stream words pass unframed, exactly as pushed.
// RL17: Stream channels are 32 bits wide.
// RL18: Streams run device to client only.
// RL19: Streams only on acquisition boards.
// RL20: Blocking read waits for data or timeout.
// RL21: Non-blocking read returns available words only.
// RL22: Requests served strictly in arrival order.
`timescale 1ns/100ps
module rap_server
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input rap_pkg::rap_word_t req_in,
	output logic req_ready_out,
	output rap_pkg::rap_word_t rsp_out,
	input wire logic rsp_ready_in,
	output logic [31:0] tgt_addr_out,
	output logic [31:0] tgt_wdata_out,
	output logic tgt_wr_out,
	output logic tgt_rd_out,
	input wire logic [31:0] tgt_rdata_in,
	input wire logic tgt_avail_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input rap_pkg::rap_word_t [3:0] push_in,
	output logic [3:0] push_ready_out,
	output rap_pkg::rap_word_t [3:0] strm_out,
	input wire logic [3:0] strm_ready_in,
	output logic [15:0] cmd_port_out,
	output logic [3:0][15:0] strm_port_out
);
	import rap_pkg::*;

	typedef enum {
		S_TAG, S_CMD, S_CNT, S_ADR, S_WR, S_TX, S_CHK, S_RD, S_CAP, S_PAY
	} rap_state_t;

	rap_state_t state_r;
	rap_hdr_t hdr_r;
	rap_word_t rsp_r;
	logic req_ready_r;
	logic [31:0] ptr_r;
	logic [31:0] idx_r;
	logic [31:0] nvalid_r;
	logic [31:0] tmr_r;
	logic [31:0] err_r;
	logic [31:0] err_nxt;
	logic [2:0] tx_sel_r;
	logic stop_r;
	logic [31:0] tgt_addr_r;
	logic [31:0] tgt_wdata_r;
	logic tgt_wr_r;
	logic tgt_rd_r;
	logic [31:0] ctrl_r;
	logic [31:0] timeout_r;
	logic [31:0] lasterr_r;
	logic [15:0] reqs_r;
	logic [31:0] reg_rdata_r;
	logic [15:0] cmd_port_r;
	logic [15:0] strm_port_r [`RAP_NCH];
	logic take;
	logic via_scb;
	logic board_ok;
	logic op_wr;
	logic op_rd;
	logic op_fix;
	logic op_blk;
	logic op_enum;
	logic last_word;

	assign req_ready_out = req_ready_r;
	assign rsp_out = rsp_r;
	assign tgt_addr_out = tgt_addr_r;
	assign tgt_wdata_out = tgt_wdata_r;
	assign tgt_wr_out = tgt_wr_r;
	assign tgt_rd_out = tgt_rd_r;
	assign reg_rdata_out = reg_rdata_r;
	assign cmd_port_out = cmd_port_r;

	////////////////////////////////////////////////////////////////////////
	// Request decode.

	assign take = req_in.valid && req_ready_r;
	assign via_scb = ctrl_r[`RAP_CTRL_VIA_SCB];
	assign last_word = 32'(idx_r + 32'h0000_0001) == hdr_r.count;

	// A board answers only its own select value; anything else is refused.
	always_comb
	begin
		if (!via_scb)
			board_ok = hdr_r.board == `RAP_BOARD_DIRECT; // see RL3
		else
			board_ok = hdr_r.board <= `RAP_BOARD_MAX && // see RL4
				hdr_r.board[2:0] ==
				ctrl_r[`RAP_CTRL_SEL_MSB:`RAP_CTRL_SEL_LSB];
	end

	always_comb
	begin
		op_wr = 1'b0;
		op_rd = 1'b0;
		op_fix = 1'b0;
		op_blk = 1'b0;
		op_enum = 1'b0;
		unique case (hdr_r.op)
			`RAP_OP_ENUM: op_enum = 1'b1; // see RL5
			`RAP_OP_WR_INC: op_wr = 1'b1; // see RL6
			`RAP_OP_WR_FIX:
			begin
				op_wr = 1'b1;
				op_fix = 1'b1;
			end
			`RAP_OP_RDB_INC: // see RL7
			begin
				op_rd = 1'b1;
				op_blk = 1'b1;
			end
			`RAP_OP_RDB_FIX:
			begin
				op_rd = 1'b1;
				op_blk = 1'b1;
				op_fix = 1'b1;
			end
			`RAP_OP_RDN_INC: op_rd = 1'b1; // see RL8
			`RAP_OP_RDN_FIX:
			begin
				op_rd = 1'b1;
				op_fix = 1'b1;
			end
			default: ;
		endcase
	end

	always_comb
	begin
		if (!board_ok)
			err_nxt = `RAP_ERR_BOARD;
		else if (!(op_wr || op_rd || op_enum))
			err_nxt = `RAP_ERR_OP;
		else
			err_nxt = `RAP_ERR_NONE;
	end

	// Board description returned by the enumerate operation, ASCII packed
	// big-end first, four characters to a word.
	function automatic logic [31:0] enum_word(input logic [31:0] i);
		case (i)
			32'h0000_0000: enum_word = 32'h7B22_626F;
			32'h0000_0001: enum_word = 32'h6172_6422;
			32'h0000_0002: enum_word = 32'h3A22_6163;
			32'h0000_0003: enum_word = 32'h7122_2C22;
			32'h0000_0004: enum_word = 32'h6669_666F;
			32'h0000_0005: enum_word = 32'h223A_347D;
			default: enum_word = 32'h0000_0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Packet sequencer. One request is parsed, executed and answered in
	// full before the next word is taken, so replies never reorder.

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			state_r <= S_TAG;
			hdr_r <= '0;
			rsp_r <= '0;
			req_ready_r <= 1'b0;
			ptr_r <= 32'h0000_0000;
			idx_r <= 32'h0000_0000;
			nvalid_r <= 32'h0000_0000;
			tmr_r <= 32'h0000_0000;
			err_r <= `RAP_ERR_NONE;
			tx_sel_r <= 3'h0;
			stop_r <= 1'b0;
			tgt_addr_r <= 32'h0000_0000;
			tgt_wdata_r <= 32'h0000_0000;
			tgt_wr_r <= 1'b0;
			tgt_rd_r <= 1'b0;
			lasterr_r <= `RAP_ERR_NONE;
			reqs_r <= 16'h0000;
		end
		else
		begin
			tgt_wr_r <= 1'b0;
			tgt_rd_r <= 1'b0;
			unique case (state_r)
				S_TAG:
				begin
					req_ready_r <= 1'b1; // see RL22
					if (take)
					begin
						hdr_r.tag <= req_in.data;
						state_r <= S_CMD;
					end
				end
				S_CMD:
					if (take)
					begin
						hdr_r.board <= req_in.data[31:16];
						hdr_r.op <= req_in.data[3:0];
						state_r <= S_CNT;
					end
				S_CNT:
					if (take)
					begin
						hdr_r.count <= req_in.data; // see RL9
						state_r <= S_ADR;
					end
				S_ADR:
					if (take)
					begin
						hdr_r.addr <= req_in.data;
						ptr_r <= req_in.data; // see RL10
						idx_r <= 32'h0000_0000;
						nvalid_r <= 32'h0000_0000;
						tmr_r <= 32'h0000_0000;
						stop_r <= 1'b0;
						tx_sel_r <= 3'h0;
						err_r <= err_nxt;
						// Refused writes still drain their payload.
						if (op_wr && hdr_r.count != 32'h0000_0000)
							state_r <= S_WR;
						else
						begin
							req_ready_r <= 1'b0;
							state_r <= S_TX;
						end
					end
				S_WR:
					if (take)
					begin
						if (err_r == `RAP_ERR_NONE)
						begin
							tgt_wr_r <= 1'b1; // see RL6
							tgt_addr_r <= ptr_r;
							tgt_wdata_r <= req_in.data;
							nvalid_r <= 32'(nvalid_r + 32'h0000_0001);
						end
						if (!op_fix)
							ptr_r <= 32'(ptr_r + 32'h0000_0001);
						idx_r <= 32'(idx_r + 32'h0000_0001);
						if (last_word)
						begin
							req_ready_r <= 1'b0;
							idx_r <= 32'h0000_0000;
							state_r <= S_TX;
						end
					end
				S_TX:
					if (!rsp_r.valid)
					begin
						rsp_r.valid <= 1'b1;
						unique case (tx_sel_r)
							3'h0: rsp_r.data <= hdr_r.tag; // see RL2
							3'h1: rsp_r.data <= // see RL11
								{hdr_r.board, 12'h000, hdr_r.op};
							3'h2: rsp_r.data <= hdr_r.count;
							3'h3: rsp_r.data <= hdr_r.addr;
							3'h4: rsp_r.data <= nvalid_r; // see RL12
							default: rsp_r.data <= err_r; // see RL13
						endcase
					end
					else if (rsp_ready_in)
					begin
						rsp_r.valid <= 1'b0;
						tx_sel_r <= 3'(tx_sel_r + 3'h1);
						if (tx_sel_r == 3'h3 && (op_rd || op_enum) &&
							hdr_r.count != 32'h0000_0000)
							state_r <= S_CHK;
						else if (tx_sel_r == 3'h5)
						begin
							lasterr_r <= err_r;
							reqs_r <= 16'(reqs_r + 16'h0001);
							state_r <= S_TAG;
						end
					end
				S_CHK:
					if (stop_r || err_r != `RAP_ERR_NONE)
					begin
						// Filler past the valid count; the client drops it.
						rsp_r <= '{valid: 1'b1, data: 32'h0000_0000};
						state_r <= S_PAY;
					end
					else if (op_enum)
					begin
						rsp_r <= '{valid: 1'b1, data: enum_word(idx_r)};
						if (idx_r < `RAP_ROM_LEN)
							nvalid_r <= 32'(nvalid_r + 32'h0000_0001);
						state_r <= S_PAY;
					end
					else if (tgt_avail_in)
					begin
						tgt_rd_r <= 1'b1;
						tgt_addr_r <= ptr_r;
						if (!op_fix)
							ptr_r <= 32'(ptr_r + 32'h0000_0001);
						state_r <= S_RD;
					end
					else if (op_blk)
					begin
						// The timeout covers the whole request. see RL20
						if (tmr_r >= timeout_r)
						begin
							stop_r <= 1'b1;
							err_r <= `RAP_ERR_TIMEOUT;
						end
						else
							tmr_r <= 32'(tmr_r + 32'h0000_0001);
					end
					else
						stop_r <= 1'b1; // see RL21
				S_RD:
					state_r <= S_CAP;
				S_CAP:
				begin
					rsp_r <= '{valid: 1'b1, data: tgt_rdata_in};
					nvalid_r <= 32'(nvalid_r + 32'h0000_0001);
					state_r <= S_PAY;
				end
				S_PAY:
					if (rsp_ready_in)
					begin
						rsp_r.valid <= 1'b0;
						idx_r <= 32'(idx_r + 32'h0000_0001);
						if (last_word)
							state_r <= S_TX;
						else
							state_r <= S_CHK;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Local register port. Read data stand one cycle after the strobe.

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			ctrl_r <= `RAP_CTRL_RST;
			timeout_r <= `RAP_TIMEOUT_RST;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `RAP_REG_CTRL)
				ctrl_r <= reg_wdata_in;
			if (reg_addr_in == `RAP_REG_TIMEOUT)
				timeout_r <= reg_wdata_in;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			reg_rdata_r <= 32'h0000_0000;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`RAP_REG_CTRL: reg_rdata_r <= ctrl_r;
				`RAP_REG_TIMEOUT: reg_rdata_r <= timeout_r;
				`RAP_REG_STATUS: reg_rdata_r <=
					{reqs_r, 15'h0000, state_r != S_TAG};
				`RAP_REG_LASTERR: reg_rdata_r <= lasterr_r;
				default: reg_rdata_r <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata_r <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Streaming channels, 32 bits each, toward the client only. They are
	// shut off while the board sits behind the slow control board.

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			cmd_port_r <= 16'h0000;
		else
			cmd_port_r <= `RAP_CMD_PORT; // see RL14
	end

	genvar ch;
	generate
		for (ch = 0; ch < `RAP_NCH; ch++)
		begin : g_strm
			// One flop array entry per channel, so no two processes share
			// one packed variable.
			always_ff @(posedge mclk_in)
			begin
				if (rst_in)
					strm_port_r[ch] <= 16'h0000;
				else
					strm_port_r[ch] <= 16'(`RAP_STRM_PORT + ch); // see RL15
			end

			assign strm_port_out[ch] = strm_port_r[ch];

			rap_stream_slice u_slice
			(
				.mclk_in(mclk_in),
				.rst_in(rst_in),
				.en_in(!via_scb), // see RL19
				.push_in(push_in[ch]), // see RL17
				.push_ready_out(push_ready_out[ch]),
				.strm_out(strm_out[ch]), // see RL18
				.strm_ready_in(strm_ready_in[ch])
			);
		end
	endgenerate
endmodule // rap_server

// ===== verif/rap_server_assertions.sv
/* Port checks of the packet server, bound to every instance.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module rap_server_assertions
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input rap_pkg::rap_word_t rsp_out,
	input wire logic rsp_ready_in,
	input wire logic req_ready_out,
	input wire logic tgt_rd_out,
	input wire logic tgt_avail_in,
	input rap_pkg::rap_word_t [3:0] push_in,
	input wire logic [3:0] push_ready_out,
	input rap_pkg::rap_word_t [3:0] strm_out,
	input wire logic [15:0] cmd_port_out,
	input wire logic [3:0][15:0] strm_port_out
);
	import rap_pkg::*;
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	property p_cmd_port;
		!$past(rst_in) |-> cmd_port_out == 16'h22C3;
	endproperty
	a_cmd_port: assert property (p_cmd_port) else $error("bad port");
	property p_strm_port;
		!$past(rst_in) |-> strm_port_out == {16'h22C7, 16'h22C6, 16'h22C5, 16'h22C4};
	endproperty
	a_strm_port: assert property (p_strm_port) else $error("bad ports");
	property p_rsp_hold;
		rsp_out.valid && !rsp_ready_in |=> rsp_out.valid && $stable(rsp_out.data);
	endproperty
	a_rsp_hold: assert property (p_rsp_hold) else $error("reply lost");
	property p_one_job;
		rsp_out.valid |-> !req_ready_out;
	endproperty
	a_one_job: assert property (p_one_job) else $error("overlap");
	property p_bubble;
		rsp_out.valid && rsp_ready_in |=> !rsp_out.valid;
	endproperty
	a_bubble: assert property (p_bubble) else $error("no gap");
	property p_rd_avail;
		tgt_rd_out |-> $past(tgt_avail_in);
	endproperty
	a_rd_avail: assert property (p_rd_avail) else $error("early read");
	property p_strm_ans;
		push_in[0].valid && push_ready_out[0] |=> strm_out[0].valid;
	endproperty
	a_strm_ans: assert property (p_strm_ans) else $error("no word");
	property p_strm_pass;
		push_in[2].valid && push_ready_out[2] && !strm_out[2].valid
			|=> strm_out[2].data == $past(push_in[2].data);
	endproperty
	a_strm_pass: assert property (p_strm_pass) else $error("altered");
	c_rsp: cover property (rsp_out.valid && rsp_ready_in);
	c_rd: cover property (tgt_rd_out);
	c_push: cover property (push_in[3].valid && push_ready_out[3]);
endmodule // rap_server_assertions
////////////////////////////////////////////////////////////////////////
bind rap_server rap_server_assertions chk
(
	.mclk_in, .rst_in, .rsp_out, .rsp_ready_in, .req_ready_out,
	.tgt_rd_out, .tgt_avail_in, .push_in, .push_ready_out,
	.strm_out, .cmd_port_out, .strm_port_out
);

// ===== verif/rap_host_model.sv
/* Host client model: sends request words and takes reply words.
   Assumes the bench top module testbench provides hang(). */
`timescale 1ns/100ps
module rap_host_model
(
	input wire logic mclk_in,
	input wire logic req_ready_in,
	input rap_pkg::rap_word_t rsp_in,
	output rap_pkg::rap_word_t req_out,
	output logic rsp_ready_out
);
	import rap_pkg::*;
	initial req_out = '0;
	initial rsp_ready_out = 1'b0;
	// Called right after an edge; the word stands until it is taken.
	task automatic send(input logic [31:0] w);
		int n;
		n = 0;
		req_out <= {1'b1, w};
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (!req_ready_in && n < 500);
		if (n >= 500)
			testbench.hang();
	endtask
	// A released line shows the inverse, so stale data cannot pass.
	task automatic rel();
		req_out <= {1'b0, ~req_out.data};
	endtask
	// Ready wanders, so replies meet both prompt and slow takers.
	task automatic recv(output logic [31:0] w);
		int n;
		n = 0;
		do
		begin
			rsp_ready_out <= 1'($urandom);
			@(posedge mclk_in);
			n++;
		end
		while (!(rsp_in.valid && rsp_ready_out) && n < 2000);
		if (n >= 2000)
			testbench.hang();
		w = rsp_in.data;
	endtask
endmodule // rap_host_model

// ===== verif/testbench.sv
/* Self-checking bench of the packet server against a word model.
   Assumes the design files and rap_regs.svh on the include path. */
`timescale 1ns/100ps
`include "rap_regs.svh"
`define CHK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s exp %h got %h", nm, ex, got); \
		end \
	end
module testbench;
	import rap_pkg::*;
	logic mclk_in, rst_in, req_ready_out, rsp_ready_in;
	logic tgt_wr_out, tgt_rd_out, tgt_avail_in, reg_wr_in, reg_rd_in;
	logic [31:0] tgt_addr_out, tgt_wdata_out, tgt_rdata_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, tag, d, sw;
	logic [31:0] mem [256], tmem [256];
	logic [31:0] sq [4][$];
	logic [3:0] reg_addr_in, push_ready_out, strm_ready_in;
	logic [15:0] cmd_port_out;
	logic [3:0][15:0] strm_port_out;
	logic [1:0] av_mode;
	rap_word_t req_in, rsp_out;
	rap_word_t [3:0] push_in, strm_out;
	int fail_count, comparisons, done;
	rap_server dut
	(
		.mclk_in, .rst_in, .req_in, .req_ready_out, .rsp_out, .rsp_ready_in,
		.tgt_addr_out, .tgt_wdata_out, .tgt_wr_out, .tgt_rd_out,
		.tgt_rdata_in, .tgt_avail_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .push_in, .push_ready_out,
		.strm_out, .strm_ready_in, .cmd_port_out, .strm_port_out
	);
	rap_host_model host
	(
		.mclk_in, .req_ready_in(req_ready_out), .rsp_in(rsp_out),
		.req_out(req_in), .rsp_ready_out(rsp_ready_in)
	);
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	////////////////////////////////////////////////////////////////////
	always @(posedge mclk_in)
	begin
		if (tgt_wr_out)
			tmem[tgt_addr_out[7:0]] <= tgt_wdata_out;
		tgt_rdata_in <= tgt_rd_out ? tmem[tgt_addr_out[7:0]] : ~tgt_rdata_in;
		tgt_avail_in <= av_mode == 2'd2 ? 1'($urandom) : av_mode[0];
		for (int c = 0; c < 4; c++)
		begin
			if (push_in[c].valid && push_ready_out[c])
				sq[c].push_back(push_in[c].data);
			if (!push_in[c].valid || push_ready_out[c])
				push_in[c] <= {1'($urandom), 32'($urandom)};
			if (strm_out[c].valid && strm_ready_in[c])
			begin
				sw = sq[c].size() ? sq[c].pop_front() : 32'hxxxx_xxxx;
				`CHK("stream word", sw, strm_out[c].data)
			end
			strm_ready_in[c] <= 1'($urandom);
		end
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		report_and_stop();
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
		@(posedge mclk_in);
	endtask
	task automatic xfer(input logic [3:0] op, input logic [15:0] brd,
		input logic [31:0] n, a, vc, err);
		logic [31:0] hdr [4];
		logic [31:0] w, e;
		logic inc;
		string js;
		hdr = '{tag, {brd, 12'h000, op}, n, a};
		js = "{\"board\":\"acq\",\"fifo\":4}";
		inc = op inside {4'h1, 4'h3, 4'h5};
		tag++;
		done++;
		foreach (hdr[i])
			host.send(hdr[i]);
		for (int k = 0; k < n && op inside {4'h1, 4'h2}; k++)
		begin
			w = $urandom;
			host.send(w);
			if (err === `RAP_ERR_NONE)
				mem[8'(a + (inc ? k : 0))] = w;
		end
		host.rel();
		foreach (hdr[i])
		begin
			host.recv(w);
			`CHK("reply header", hdr[i], w)
		end
		for (int k = 0; k < n && !(op inside {4'h1, 4'h2}); k++)
		begin
			host.recv(w);
			e = k >= vc ? 32'h0000_0000 : mem[8'(a + (inc ? k : 0))];
			if (op == 4'h0 && k < vc)
				e = {js[4*k], js[4*k+1], js[4*k+2], js[4*k+3]};
			`CHK("payload", e, w)
		end
		host.recv(w);
		`CHK("valid count", vc, w)
		host.recv(w);
		`CHK("completion", err, w)
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_in = 1'b1;
		tgt_rdata_in = '0;
		tgt_avail_in = 1'b0;
		reg_addr_in = '0;
		reg_wdata_in = '0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		push_in = '0;
		strm_ready_in = '0;
		av_mode = 2'd1;
		tag = 32'h0000_0001;
		fail_count = 0;
		comparisons = 0;
		done = 0;
		void'($urandom(32'hc44b));
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		`CHK("command port", 16'h22C3, cmd_port_out)
		for (int c = 0; c < 4; c++)
			`CHK("stream port", 16'(16'h22C4 + c), strm_port_out[c])
		reg_rd(4'h4, d);
		`CHK("timeout reset", `RAP_TIMEOUT_RST, d)
		reg_rd(4'hC, d);
		`CHK("last error reset", 32'hFFFF_FFFF, d)
		reg_rd(4'h1, d);
		`CHK("unmapped", 32'h0000_0000, d)
		reg_wr(4'h4, 32'h0000_00C8);
		reg_rd(4'h4, d);
		`CHK("timeout", 32'h0000_00C8, d)
		for (int op = 1; op < 7; op++)
		begin
			av_mode = op inside {3, 4} ? 2'd2 : 2'd1;
			xfer(4'(op), 16'hFFFF, op % 2 ? 3 : 2, op % 2 ? 16 : 40,
				op % 2 ? 3 : 2, `RAP_ERR_NONE);
		end
		xfer(4'h0, 16'hFFFF, 8, 0, 6, `RAP_ERR_NONE);
		xfer(4'h3, 16'h0001, 2, 16, 0, `RAP_ERR_BOARD);
		xfer(4'h7, 16'hFFFF, 0, 0, 0, `RAP_ERR_OP);
		av_mode = 2'd0;
		xfer(4'h5, 16'hFFFF, 2, 16, 0, `RAP_ERR_NONE);
		xfer(4'h4, 16'hFFFF, 1, 40, 0, `RAP_ERR_TIMEOUT);
		reg_rd(4'hC, d);
		`CHK("last error", `RAP_ERR_TIMEOUT, d)
		reg_wr(4'h0, 32'h0000_0201);
		reg_rd(4'h0, d);
		`CHK("control", 32'h0000_0201, d)
		av_mode = 2'd1;
		xfer(4'h3, 16'h0002, 1, 16, 1, `RAP_ERR_NONE);
		`CHK("push gate", 4'h0, push_ready_out)
		xfer(4'h3, 16'hFFFF, 1, 16, 0, `RAP_ERR_BOARD);
		reg_wr(4'h0, 32'h0000_0000);
		reg_rd(4'h8, d);
		`CHK("replies done", 16'(done), d[31:16])
		`CHK("idle", 1'b0, d[0])
		report_and_stop();
	end
endmodule // testbench
